// File: rtl/fpf_hazard_fwd.sv
// Overview of operation
// RQ1 - Hazard: two-cycle producer then matching float-to-core move.
// RQ2 - Hazard makes the move deliver the old value.
// RQ3 - Producer result is forwarded in third execute phase.
// RQ4 - Stall in third execute phase defeats forwarding.
// RQ5 - Producers: multiply, add, subtract, multiply-accumulate only.
// RQ6 - Only moves into core registers read stale.
// RQ7 - Float-to-float moves always get the forwarded result.
// RQ8 - Move samples its source entering second read phase.
// RQ9 - Without stalls, forwarding gives two-cycle apparent latency.
// RQ10 - Software keeps three slots before dependent move.
// RQ11 - Read phases then three execute phases, shared pipeline.
module fpf_hazard_fwd (
    input wire logic ref_clk, // Pipeline clock, 10 MHz.
    input wire logic sys_rst, // Synchronous reset, active high.
    input fpf_pkg::fpf_instr_t issue, // Instruction entering first read.
    output logic issue_ready, // High when the issue slot is free.
    input wire logic pipe_stall, // Whole pipeline holds this cycle.
    input wire logic [fpf_pkg::DATA_W-1:0] fpu_e3_result, // E3 producer result.
    output fpf_pkg::fpf_instr_t e3_instr, // Instruction now in E3.
    output fpf_pkg::fpf_core_wr_t core_wr, // Write to core registers.
    output logic stale_read // Pulse: move sampled a stale value.
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    // Instruction held in each tracked slot.
    fpf_pkg::fpf_instr_t stg_ff [fpf_pkg::STAGES];
    // Operand carried alongside a move from E1 to E3.
    logic [fpf_pkg::DATA_W-1:0] opd_ff [fpf_pkg::ST_E1:fpf_pkg::ST_E3];
    // Operand captured by the move sitting in the second read slot.
    logic [fpf_pkg::DATA_W-1:0] r2_opd_ff;
    // Set once the move in the second read slot has sampled.
    logic r2_smp_ff;
    // Float register file.
    logic [fpf_pkg::DATA_W-1:0] flt_rf_ff [fpf_pkg::FLT_REGS];
    // Registered core write and stale flag.
    fpf_pkg::fpf_core_wr_t core_wr_ff;
    logic stale_ff;

    fpf_pkg::fpf_instr_t r2_ins; // Instruction in the second read slot.
    fpf_pkg::fpf_instr_t e3_ins; // Instruction in the third execute slot.
    logic e3_prod; // A two-cycle producer sits in E3.
    logic r2_f2c; // A float-to-core move sits in R2.
    logic r2_f2f; // A float-to-float move sits in R2.
    logic src_match; // R2 source equals E3 destination.
    logic fwd_hit; // Forwarding from E3 reaches R2 this cycle.
    logic [fpf_pkg::DATA_W-1:0] live_opd; // Value R2 would sample now.
    logic [fpf_pkg::DATA_W-1:0] r2_opd; // Operand R2 hands to E1.
    logic nxt_stale; // Stale sample taken this cycle.

    ////////////////////////////////////////////////////////////////////////
    // Hazard detection and forwarding.

    assign r2_ins = stg_ff[fpf_pkg::ST_R2];
    assign e3_ins = stg_ff[fpf_pkg::ST_E3];

    // The next instruction may only enter while the pipeline moves.
    assign issue_ready = !pipe_stall;

    // Classify the producer in E3 and the reader in R2.
    always_comb begin
        // RQ5 affected producers
        e3_prod = e3_ins.valid &&
            (e3_ins.op == fpf_pkg::OP_FLOAT_MULTIPLY ||
             e3_ins.op == fpf_pkg::OP_FLOAT_ADD ||
             e3_ins.op == fpf_pkg::OP_FLOAT_SUBTRACT ||
             e3_ins.op == fpf_pkg::OP_FLOAT_MULTIPLY_ACC);
        // RQ6 core destination moves
        r2_f2c = r2_ins.valid && r2_ins.op == fpf_pkg::OP_MOVE_FLT_TO_CORE;
        r2_f2f = r2_ins.valid && r2_ins.op == fpf_pkg::OP_MOVE_FLT_TO_FLT;
        // RQ1 hazard source match
        src_match = e3_prod && (e3_ins.dst == r2_ins.src);
    end

    // Forwarding path into the second read slot. The core-read path taps
    // the E3 result only while the pipeline moves, so a stall there lets
    // the move see the register file instead. The float-to-float path has
    // its own tap that holds through the stall.
    always_comb begin
        // RQ3 forward in E3
        // RQ4 stall defeats forwarding
        // RQ7 float moves forwarded
        fwd_hit = src_match && (r2_f2f || !pipe_stall);
        // Producers still in E1 or E2 are not forwarded at all; the
        // instruction stream keeps them three slots ahead.
        // RQ10 software spacing relied on
        if (fwd_hit) begin
            live_opd = fpu_e3_result;
        end else begin
            live_opd = flt_rf_ff[r2_ins.src];
        end
        // RQ8 sample entering R2
        if (r2_f2f || !r2_smp_ff) begin
            r2_opd = live_opd;
        end else begin
            r2_opd = r2_opd_ff;
        end
        // RQ2 stale value delivered
        nxt_stale = r2_f2c && !r2_smp_ff && src_match && pipe_stall;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pipeline slots.

    // All slots move together; a stall freezes every slot at once.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < fpf_pkg::STAGES; i++) begin
                stg_ff[i] <= '0;
            end
        end else if (!pipe_stall) begin
            // RQ11 shared pipeline shift
            stg_ff[fpf_pkg::ST_R1] <= issue;
            for (int i = 1; i < fpf_pkg::STAGES; i++) begin
                stg_ff[i] <= stg_ff[i-1];
            end
        end
    end

    // Operand capture in R2. A core move keeps its first sample through a
    // stall, which is what lets a stale value survive.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            r2_opd_ff <= fpf_pkg::DATA_RST;
            r2_smp_ff <= 1'b0;
        end else if (pipe_stall) begin
            // RQ8 hold first sample
            r2_opd_ff <= r2_opd;
            r2_smp_ff <= r2_ins.valid;
        end else begin
            // A new instruction arrives and has not sampled yet.
            r2_opd_ff <= fpf_pkg::DATA_RST;
            r2_smp_ff <= 1'b0;
        end
    end

    // Operands travel with their move through the execute slots.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = fpf_pkg::ST_E1; i <= fpf_pkg::ST_E3; i++) begin
                opd_ff[i] <= fpf_pkg::DATA_RST;
            end
        end else if (!pipe_stall) begin
            opd_ff[fpf_pkg::ST_E1] <= r2_opd;
            for (int i = fpf_pkg::ST_E2; i <= fpf_pkg::ST_E3; i++) begin
                opd_ff[i] <= opd_ff[i-1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes.

    // Float results retire as E3 completes; the write lands one cycle
    // after the forward, which is why forwarding is needed at all.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < fpf_pkg::FLT_REGS; i++) begin
                flt_rf_ff[i] <= fpf_pkg::DATA_RST;
            end
        end else if (!pipe_stall && e3_prod) begin
            // RQ9 result retires late
            flt_rf_ff[e3_ins.dst] <= fpu_e3_result;
        end else if (!pipe_stall && e3_ins.valid &&
                e3_ins.op == fpf_pkg::OP_MOVE_FLT_TO_FLT) begin
            flt_rf_ff[e3_ins.dst] <= opd_ff[fpf_pkg::ST_E3];
        end
    end

    // Core register write from a float-to-core move leaving E3.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            core_wr_ff <= '0;
        end else begin
            core_wr_ff.valid <= !pipe_stall && e3_ins.valid &&
                e3_ins.op == fpf_pkg::OP_MOVE_FLT_TO_CORE;
            core_wr_ff.core_dst <= e3_ins.core_dst;
            core_wr_ff.data <= opd_ff[fpf_pkg::ST_E3];
        end
    end

    // Stale-read flag, one cycle after the bad sample.
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stale_ff <= 1'b0;
        end else begin
            stale_ff <= nxt_stale;
        end
    end

    assign e3_instr = e3_ins;
    assign core_wr = core_wr_ff;
    assign stale_read = stale_ff;

    ////////////////////////////////////////////////////////////////////////
    // Assertions and cover points.

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    chk_stall_stale: assert property ( // RQ4
        r2_f2c && !r2_smp_ff && src_match && pipe_stall |=> stale_read)
        else $error("stall in E3 did not flag a stale read");

    chk_forward_nostall: assert property ( // RQ3
        r2_f2c && !r2_smp_ff && src_match && !pipe_stall
        |=> opd_ff[fpf_pkg::ST_E1] == $past(fpu_e3_result) && !stale_read)
        else $error("forwarded result missing without stall");

    chk_float_move_fwd: assert property ( // RQ7
        r2_f2f && src_match |-> r2_opd == fpu_e3_result)
        else $error("float-to-float move missed forwarding");

    chk_stale_value: assert property ( // RQ2
        nxt_stale |-> r2_opd == flt_rf_ff[r2_ins.src])
        else $error("stale read did not take register value");

    chk_hazard_cond: assert property ( // RQ1
        stale_read |-> $past(e3_ins.dst) == $past(r2_ins.src))
        else $error("stale flag without matching registers");

    chk_producer_kind: assert property ( // RQ5
        stale_read |-> $past(e3_ins.op) inside {
            fpf_pkg::OP_FLOAT_MULTIPLY, fpf_pkg::OP_FLOAT_ADD,
            fpf_pkg::OP_FLOAT_SUBTRACT, fpf_pkg::OP_FLOAT_MULTIPLY_ACC})
        else $error("stale flag from unaffected producer");

    chk_core_reader: assert property ( // RQ6
        stale_read |-> $past(r2_ins.op) == fpf_pkg::OP_MOVE_FLT_TO_CORE)
        else $error("stale flag for a non-core move");

    chk_sample_hold: assert property ( // RQ8
        r2_f2c && r2_smp_ff && pipe_stall |=> $stable(r2_opd_ff))
        else $error("core move resampled during stall");

    chk_move_retire: assert property ( // RQ9
        r2_f2c && !pipe_stall ##1 !pipe_stall [*3]
        |=> core_wr.valid && core_wr.data == $past(opd_ff[fpf_pkg::ST_E3]))
        else $error("core move did not retire after three slots");

    chk_pipe_shift: assert property ( // RQ11
        !pipe_stall |=> stg_ff[fpf_pkg::ST_E3] == $past(stg_ff[fpf_pkg::ST_E2]))
        else $error("pipeline did not advance");

    cov_stale_hazard: cover property (stale_read);
    cov_clean_forward: cover property (
        r2_f2c && src_match && !pipe_stall);
    cov_float_move_stall: cover property (
        r2_f2f && src_match && pipe_stall);
    cov_core_write: cover property (core_wr.valid);

endmodule : fpf_hazard_fwd

// File: rtl/fpf_pkg.sv
package fpf_pkg;

    // Width of a float register and of a core register write.
    localparam int DATA_W = 32;
    // Number of float registers held in the float register file.
    localparam int FLT_REGS = 8;
    // Width of a float register index.
    localparam int FLT_IDX_W = 3;
    // Width of a core destination code.
    localparam int CORE_DST_W = 4;
    // Reset value of every data flip-flop.
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

    // Pipeline slots that the block tracks, from operand read to execute.
    localparam int ST_R1 = 0;
    localparam int ST_R2 = 1;
    localparam int ST_E1 = 2;
    localparam int ST_E2 = 3;
    localparam int ST_E3 = 4;
    localparam int STAGES = 5;

    // Core destinations of a float-to-core move.
    localparam logic [CORE_DST_W-1:0] CORE_ACC = 4'h0;
    localparam logic [CORE_DST_W-1:0] CORE_PRODUCT = 4'h1;
    localparam logic [CORE_DST_W-1:0] CORE_MULTIPLICAND = 4'h2;
    localparam logic [CORE_DST_W-1:0] CORE_AUX_BASE = 4'h3;

    // Operation classes that the hazard logic distinguishes.
    typedef enum logic [2:0] {
        OP_NONE,
        OP_FLOAT_MULTIPLY,
        OP_FLOAT_ADD,
        OP_FLOAT_SUBTRACT,
        OP_FLOAT_MULTIPLY_ACC,
        OP_MOVE_FLT_TO_CORE,
        OP_MOVE_FLT_TO_FLT,
        OP_OTHER
    } fpf_op_t;

    // One instruction as it travels through the tracked slots.
    typedef struct packed {
        logic valid;
        fpf_op_t op;
        logic [FLT_IDX_W-1:0] dst;
        logic [FLT_IDX_W-1:0] src;
        logic [CORE_DST_W-1:0] core_dst;
    } fpf_instr_t;

    // One write into the core register file.
    typedef struct packed {
        logic valid;
        logic [CORE_DST_W-1:0] core_dst;
        logic [DATA_W-1:0] data;
    } fpf_core_wr_t;

endpackage : fpf_pkg

// File: dv/fpf_core_model.sv
// Far side model: the float datapath result and the core register file.
module fpf_core_model (
    input wire logic ref_clk, // Pipeline clock.
    input fpf_pkg::fpf_instr_t e3_instr, // Instruction now in E3.
    input fpf_pkg::fpf_core_wr_t core_wr, // Write into core registers.
    output logic [fpf_pkg::DATA_W-1:0] fpu_e3_result // Result of E3 slot.
);
    timeunit 1ns;
    timeprecision 1ns;
    // Core register file, one word per destination code.
    logic [fpf_pkg::DATA_W-1:0] core_regs [16];
    // Last value driven, so an idle result line keeps changing.
    logic [fpf_pkg::DATA_W-1:0] last_ff = 32'h0000_0000;
    // High while a two-cycle producer sits in E3.
    logic is_prod;

    ////////////////////////////////////////////////////////////////////////
    // producer ops only
    assign is_prod = e3_instr.valid
        && e3_instr.op >= fpf_pkg::OP_FLOAT_MULTIPLY
        && e3_instr.op <= fpf_pkg::OP_FLOAT_MULTIPLY_ACC;
    // result held in E3
    // An idle line shows the inverse of the last value, never a stale copy.
    assign fpu_e3_result = is_prod
        ? (32'hC0DE_0000 | {26'h0, e3_instr.op, e3_instr.dst}) : ~last_ff;

    // Track the driven value and take every core write.
    always @(posedge ref_clk) begin
        last_ff <= fpu_e3_result;
        if (core_wr.valid === 1'b1) begin
            core_regs[core_wr.core_dst] <= core_wr.data;
        end
    end
endmodule : fpf_core_model

// File: dv/fpf_hazard_fwd_bench.sv
// Self-checking bench for the float forwarding hazard block.
module fpf_hazard_fwd_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0; // Clock, 100 ns period.
    logic sys_rst = 1'b1; // Held for two cycles at start.
    logic pipe_stall = 1'b0; // Stall request.
    fpf_pkg::fpf_instr_t issue = '0; // Instruction issued.
    fpf_pkg::fpf_instr_t e3_instr; // Instruction in E3.
    fpf_pkg::fpf_core_wr_t core_wr; // Core write seen.
    logic [fpf_pkg::DATA_W-1:0] fpu_e3_result; // Result from model.
    logic issue_ready; // Issue slot free.
    logic stale_read; // Stale pulse.
    logic saw_stale = 1'b0; // Sticky copy of the stale pulse.
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;

    always #50 ref_clk = ~ref_clk;

    fpf_hazard_fwd fpf_hazard_fwd_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .issue(issue), .issue_ready(issue_ready), .pipe_stall(pipe_stall),
        .fpu_e3_result(fpu_e3_result), .e3_instr(e3_instr),
        .core_wr(core_wr), .stale_read(stale_read));
    fpf_core_model fpf_core_model_i (.ref_clk(ref_clk), .e3_instr(e3_instr),
        .core_wr(core_wr), .fpu_e3_result(fpu_e3_result));

    ////////////////////////////////////////////////////////////////////////
    // The pulse lasts one cycle, so it is latched for later judging.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (stale_read === 1'b1) begin
            saw_stale <= 1'b1;
        end
        if (cycles == 3000) begin
            failures++;
            summarize();
        end
    end

    // Report and end the run.
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    // Compare one value and count it.
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    function automatic fpf_pkg::fpf_instr_t mk(fpf_pkg::fpf_op_t op,
        logic [2:0] dst, logic [2:0] src, logic [3:0] cd);
        return '{1'b1, op, dst, src, cd};
    endfunction : mk

    // Value the model gives a producer; kept apart from the model itself.
    function automatic logic [31:0] res(fpf_pkg::fpf_op_t op, logic [2:0] d);
        return 32'hC0DE_0000 | {26'h0, op, d};
    endfunction : res

    task automatic put(fpf_pkg::fpf_instr_t x);
        @(posedge ref_clk);
        issue <= x;
    endtask : put

    // Producer, two slots, then the reader, so that the reader enters R2
    // just as the producer enters E3; optional stall while P is in E3.
    task automatic run(fpf_pkg::fpf_instr_t p, fpf_pkg::fpf_instr_t m,
        logic stall);
        put(p);
        put('0);
        put('0);
        put(m);
        put('0);
        @(posedge ref_clk);
        pipe_stall <= stall;
        @(negedge ref_clk);
        check("e3 op", 32'(p.op), 32'(e3_instr.op));
        check("ready", 32'(!stall), 32'(issue_ready));
        @(posedge ref_clk);
        pipe_stall <= 1'b0;
    endtask : run

    // Wait, bounded, for the core write and judge it.
    task automatic expect_wr(logic [3:0] cd, logic [31:0] d, logic stl);
        for (int k = 0; k < 20; k++) begin
            @(negedge ref_clk);
            if (core_wr.valid === 1'b1) begin
                break;
            end
        end
        check("wr valid", 32'h1, 32'(core_wr.valid));
        check("wr dst", 32'(cd), 32'(core_wr.core_dst));
        check("wr data", d, core_wr.data);
        check("stale", 32'(stl), 32'(saw_stale));
        saw_stale = 1'b0;
    endtask : expect_wr

    ////////////////////////////////////////////////////////////////////////
    // forward all producers
    task automatic t_forward();
        fpf_pkg::fpf_op_t op;
        for (int i = 1; i <= 4; i++) begin
            op = fpf_pkg::fpf_op_t'(i);
            run(mk(op, 3'(i), 3'h0, 4'h0),
                mk(fpf_pkg::OP_MOVE_FLT_TO_CORE, 3'h0, 3'(i), 4'(3 * i - 3)),
                1'b0);
            expect_wr(4'(3 * i - 3), res(op, 3'(i)), 1'b0);
        end
    endtask : t_forward

    task automatic t_stall();
        run(mk(fpf_pkg::OP_FLOAT_MULTIPLY, 3'h2, 3'h0, 4'h0),
            mk(fpf_pkg::OP_MOVE_FLT_TO_CORE, 3'h0, 3'h2,
            fpf_pkg::CORE_PRODUCT), 1'b1);
        expect_wr(fpf_pkg::CORE_PRODUCT, res(fpf_pkg::OP_FLOAT_ADD, 3'h2),
            1'b1);
    endtask : t_stall

    task automatic t_flt_move();
        run(mk(fpf_pkg::OP_FLOAT_SUBTRACT, 3'h5, 3'h0, 4'h0),
            mk(fpf_pkg::OP_MOVE_FLT_TO_FLT, 3'h6, 3'h5, 4'h0), 1'b1);
        repeat (4) put('0);
        put(mk(fpf_pkg::OP_MOVE_FLT_TO_CORE, 3'h0, 3'h6, 4'hA));
        expect_wr(4'hA, res(fpf_pkg::OP_FLOAT_SUBTRACT, 3'h5), 1'b0);
    endtask : t_flt_move

    task automatic t_not_prod();
        run(mk(fpf_pkg::OP_OTHER, 3'h1, 3'h0, 4'h0),
            mk(fpf_pkg::OP_MOVE_FLT_TO_CORE, 3'h0, 3'h1,
            fpf_pkg::CORE_ACC), 1'b1);
        expect_wr(fpf_pkg::CORE_ACC, res(fpf_pkg::OP_FLOAT_MULTIPLY, 3'h1),
            1'b0);
    endtask : t_not_prod

    initial begin
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_forward();
        t_stall();
        t_flt_move();
        t_not_prod();
        summarize();
    end
endmodule : fpf_hazard_fwd_bench
